//--- hdl/irq_router_consts.vh
/*
 Constants for the system interrupt router: register byte addresses,
 control bit positions, counter widths, source indices and group masks.
 Assumes inclusion by the router only; definitions only.
*/
`ifndef IRQ_ROUTER_CONSTS_VH
`define IRQ_ROUTER_CONSTS_VH

// Register byte addresses on the APB slave
`define A_PEND0    8'h00
`define A_PEND1    8'h04
`define A_SMASK0   8'h08
`define A_SMASK1   8'h0c
`define A_PMASK    8'h10
`define A_AMASK    8'h14
`define A_TOPSTAT  8'h18
`define A_MODE     8'h1c
`define A_CTRL     8'h20
`define A_SWSET    8'h24
`define A_TLOAD    8'h28
`define A_WLOAD    8'h2c
`define A_PLOAD    8'h30
`define A_TCOUNT   8'h34

// Control register bits
`define C_TO_EN    0
`define C_TM_EN    1
`define C_WD_EN    2
`define C_PM_EN    3
`define C_RST_IRQ  4
`define CTRL_W     5

// Mode register: edge select in low half, polarity in high half
`define MODE_POL   16
`define N_CFG      12
`define N_SRC      64
`define N_GRP      9
`define N_SW       2

// Bus timeout: event raised after this many cycles without answer
`define TO_CYC     11'd1024
`define TO_W       11
`define PM_W       16

// Selected source positions
`define S_WDOG     14

// Subsystem groups over the 64 pending bits
`define G_PIN      64'h0000_0000_0000_00ff
`define G_FAB      64'h0000_0000_0000_0f00
`define G_CPU      64'h0000_0000_0200_f000
`define G_FUS      64'h0000_0000_01ff_0000
`define G_AON      64'h0180_0000_3c00_0000
`define G_DMA      64'h0000_0fff_4000_0000
`define G_FIFO     64'h0000_0000_8000_0000
`define G_VOICE    64'h003f_f000_0000_0000
`define G_CFG      64'h0040_0000_0000_0000

// Every source wakes the processor except system DMA channel 0
`define WAKE_SET   64'hffff_fffe_ffff_ffff

`endif

//--- hdl/system_interrupt_router.v
/*
 System interrupt router: source-level pending and masks, subsystem
 combining, top-level status with separate processor and application
 processor masks, internal timers, bus timeout, wake-up, APB registers.
 Assumes all inputs synchronous to CLOCK; event inputs are pulses or
 levels, PM_TICK is a one-cycle strobe per 32 kHz period.
*/
// The APB interface to the registers and the register addresses were decided locally.
`include "irq_router_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module system_interrupt_router (
   input  wire        CLOCK,
   input  wire        RST_N,
   input  wire        PSEL,
   input  wire        PENABLE,
   input  wire        PWRITE,
   input  wire [7:0]  PADDR,
   input  wire [31:0] PWDATA,
   output reg  [31:0] PRDATA,
   output wire        PREADY,
   output wire        PSLVERR,
   input  wire [7:0]  PIN_IRQ,
   input  wire [3:0]  FABRIC_IRQ,
   input  wire        BUS_ACC,
   input  wire        BUS_RESP,
   input  wire [15:0] SRAM_ACC,
   input  wire [15:0] SRAM_LOWPWR,
   input  wire [7:0]  FUSION_MSG,
   input  wire [15:0] FUSION_SUB,
   input  wire [4:0]  SERIAL_IRQ,
   input  wire        SYS_RESET_PIN_N,
   input  wire        PM_TICK,
   input  wire [11:0] DMA_DONE,
   input  wire        DMA_ERR,
   input  wire [19:0] FIFO_EVT,
   input  wire [9:0]  VOICE_IRQ,
   input  wire        CFG_DMA_DONE,
   input  wire        BOOT_FLASH,
   input  wire        ADC_DONE,
   input  wire        RTC_ALARM,
   output reg  [8:0]  PROC_IRQ,
   output reg         APP_IRQ,
   output reg         PROC_WAKE,
   output reg         WDOG_RESET,
   output reg         SYS_RESET_OUT
);

////////////////////////////////////////////////////////////////////////
// Registers
reg  [63:0]          pend_r;
reg  [63:0]          smask_r;
reg  [8:0]           pmask_r;
reg  [8:0]           amask_r;
reg  [8:0]           top_r;
reg  [31:0]          mode_r;
reg  [`CTRL_W-1:0]   ctrl_r;
reg  [31:0]          tload_r;
reg  [31:0]          wload_r;
reg  [`PM_W-1:0]     pload_r;
reg  [31:0]          tcnt_r;
reg  [31:0]          wcnt_r;
reg  [`PM_W-1:0]     pcnt_r;
reg  [`TO_W-1:0]     tocnt_r;
reg  [`N_CFG-1:0]    prev_r;
reg                  rpin_r;

wire [63:0]          pend_nxt;
wire [63:0]          evt;
wire [63:0]          clr;
wire [8:0]           grp;
wire                 to_ev;
wire                 tm_ev;
wire                 wd_ev;
wire                 pm_ev;
wire                 sram_ev;
wire                 rst_ev;
wire [`N_SW-1:0]     sw_ev;
wire                 cfg_ev;

////////////////////////////////////////////////////////////////////////
// APB slave: zero wait states, read data captured in the setup phase
wire acc    = PSEL & PENABLE;
wire wr     = acc & PWRITE;
wire setup  = PSEL & ~PENABLE;
reg  mapped;
reg  [31:0] rd_nxt;

always @* begin
   mapped = 1'b1;
   rd_nxt = 32'h0000_0000;
   case (PADDR)
      `A_PEND0:   rd_nxt = pend_r[31:0];
      `A_PEND1:   rd_nxt = pend_r[63:32];
      `A_SMASK0:  rd_nxt = smask_r[31:0];
      `A_SMASK1:  rd_nxt = smask_r[63:32];
      `A_PMASK:   rd_nxt = {23'h000000, pmask_r};
      `A_AMASK:   rd_nxt = {23'h000000, amask_r};
      `A_TOPSTAT: rd_nxt = {22'h000000, PROC_WAKE, top_r};
      `A_MODE:    rd_nxt = mode_r;
      `A_CTRL:    rd_nxt = {27'h0000000, ctrl_r};
      `A_SWSET:   rd_nxt = 32'h0000_0000;
      `A_TLOAD:   rd_nxt = tload_r;
      `A_WLOAD:   rd_nxt = wload_r;
      `A_PLOAD:   rd_nxt = {16'h0000, pload_r};
      `A_TCOUNT:  rd_nxt = tcnt_r;
      default: begin
         mapped = 1'b0;
         rd_nxt = 32'h0000_0000;
      end
   endcase
end

assign PREADY  = 1'b1;
assign PSLVERR = acc & ~mapped;

always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      PRDATA <= 32'h0000_0000;
   end else if (setup) begin
      PRDATA <= rd_nxt;
   end
end

wire wr_pend0 = wr & (PADDR == `A_PEND0);
wire wr_pend1 = wr & (PADDR == `A_PEND1);
wire wr_top   = wr & (PADDR == `A_TOPSTAT);
wire wr_sw    = wr & (PADDR == `A_SWSET);

// Writing ones clears pending bits at the source
assign clr = {(wr_pend1 ? PWDATA : 32'h0000_0000),
              (wr_pend0 ? PWDATA : 32'h0000_0000)};

always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      smask_r <= 64'h0000_0000_0000_0000;
      pmask_r <= 9'h000;
      amask_r <= 9'h000;
      mode_r  <= 32'h0000_0000;
      ctrl_r  <= 5'h00;
      tload_r <= 32'h0000_0000;
      wload_r <= 32'h0000_0000;
      pload_r <= 16'h0000;
   end else if (wr) begin
      case (PADDR)
         `A_SMASK0: smask_r[31:0]  <= PWDATA;
         `A_SMASK1: smask_r[63:32] <= PWDATA;
         `A_PMASK:  pmask_r <= PWDATA[8:0];
         `A_AMASK:  amask_r <= PWDATA[8:0];
         `A_MODE:   mode_r  <= PWDATA;
         `A_CTRL:   ctrl_r  <= PWDATA[`CTRL_W-1:0];
         `A_TLOAD:  tload_r <= PWDATA;
         `A_WLOAD:  wload_r <= PWDATA;
         `A_PLOAD:  pload_r <= PWDATA[`PM_W-1:0];
         default:   ctrl_r  <= ctrl_r;
      endcase
   end
end

////////////////////////////////////////////////////////////////////////
// Event generators
// Bus timeout counter restarts on every answer or idle bus
always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      tocnt_r <= 11'd0;
   end else if (!BUS_ACC || BUS_RESP) begin
      tocnt_r <= 11'd0;
   end else if (tocnt_r != `TO_CYC) begin
      tocnt_r <= tocnt_r + 11'd1;
   end
end
// Fires once, in the cycle that completes the wait
assign to_ev = ctrl_r[`C_TO_EN] & BUS_ACC & ~BUS_RESP
             & (tocnt_r == `TO_CYC - 11'd1);

// General timer reloads on zero so it fires periodically
assign tm_ev = ctrl_r[`C_TM_EN] & (tcnt_r == 32'h0000_0000);
always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      tcnt_r <= 32'h0000_0000;
   end else if (!ctrl_r[`C_TM_EN] || tm_ev) begin
      tcnt_r <= tload_r;
   end else begin
      tcnt_r <= tcnt_r - 32'h0000_0001;
   end
end

// Watchdog: first zero raises the event, a zero with it still
// pending resets the system instead
assign wd_ev = ctrl_r[`C_WD_EN] & (wcnt_r == 32'h0000_0000);
always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      wcnt_r     <= 32'h0000_0000;
      WDOG_RESET <= 1'b0;
   end else begin
      WDOG_RESET <= wd_ev & pend_r[`S_WDOG];
      if (!ctrl_r[`C_WD_EN] || wd_ev) begin
         wcnt_r <= wload_r;
      end else begin
         wcnt_r <= wcnt_r - 32'h0000_0001;
      end
   end
end

// Power manager timer advances only on the slow tick
assign pm_ev = ctrl_r[`C_PM_EN] & PM_TICK
             & (pcnt_r == 16'h0000);
always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      pcnt_r <= 16'h0000;
   end else if (!ctrl_r[`C_PM_EN] || pm_ev) begin
      pcnt_r <= pload_r;
   end else if (PM_TICK) begin
      pcnt_r <= pcnt_r - 16'h0001;
   end
end

assign sram_ev = |(SRAM_ACC & SRAM_LOWPWR);
assign sw_ev   = wr_sw ? PWDATA[`N_SW-1:0] : 2'b00;
assign cfg_ev  = CFG_DMA_DONE & BOOT_FLASH;

// Reset pin: a falling edge is an event when rerouted, else a reset
assign rst_ev = ctrl_r[`C_RST_IRQ] & rpin_r & ~SYS_RESET_PIN_N;
always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      rpin_r        <= 1'b1;
      SYS_RESET_OUT <= 1'b0;
   end else begin
      rpin_r        <= SYS_RESET_PIN_N;
      SYS_RESET_OUT <= ~ctrl_r[`C_RST_IRQ] & ~SYS_RESET_PIN_N;
   end
end

////////////////////////////////////////////////////////////////////////
// Source vector
assign evt = {7'h00, RTC_ALARM, ADC_DONE, cfg_ev,
              VOICE_IRQ,
              DMA_DONE,
              |FIFO_EVT,
              DMA_ERR,
              pm_ev, rst_ev, sw_ev,
              |SERIAL_IRQ,
              |FUSION_SUB,
              FUSION_MSG,
              sram_ev, wd_ev, tm_ev, to_ev,
              FABRIC_IRQ,
              PIN_IRQ};

always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      prev_r <= 12'h000;
      pend_r <= 64'h0000_0000_0000_0000;
   end else begin
      prev_r <= evt[`N_CFG-1:0];
      pend_r <= pend_nxt;
   end
end

// Configurable sources pick edge or level and polarity; the rest
// are pulses that latch. A new event beats a clear in the same cycle.
genvar i;
generate
   for (i = 0; i < `N_SRC; i = i + 1) begin : g_src
      if (i < `N_CFG) begin : g_cfg
         wire edge_m = mode_r[i];
         wire pol    = mode_r[`MODE_POL + i];
         wire act    = pol ? evt[i] : ~evt[i];
         wire hit    = pol ? (evt[i] & ~prev_r[i])
                           : (~evt[i] & prev_r[i]);
         assign pend_nxt[i] = edge_m ? (hit | (pend_r[i] & ~clr[i]))
                                     : act;
      end else begin : g_fix
         assign pend_nxt[i] = evt[i] | (pend_r[i] & ~clr[i]);
      end
   end
endgenerate

////////////////////////////////////////////////////////////////////////
// Subsystem combining and top level
wire [63:0] live = pend_r & smask_r;
assign grp = {|(live & `G_CFG), |(live & `G_VOICE), |(live & `G_FIFO),
              |(live & `G_DMA), |(live & `G_AON),   |(live & `G_FUS),
              |(live & `G_CPU), |(live & `G_FAB),   |(live & `G_PIN)};

always @(posedge CLOCK or negedge RST_N) begin
   if (!RST_N) begin
      top_r     <= 9'h000;
      PROC_IRQ  <= 9'h000;
      APP_IRQ   <= 1'b0;
      PROC_WAKE <= 1'b0;
   end else begin
      // Top status: set wins over the write-one clear
      top_r     <= grp | (top_r & ~(wr_top ? PWDATA[8:0] : 9'h000));
      PROC_IRQ  <= top_r & pmask_r;
      APP_IRQ   <= |(top_r & amask_r);
      PROC_WAKE <= |(live & `WAKE_SET);
   end
end

endmodule

`default_nettype wire

//--- test/router_checker.sv
/*
 Checker for the interrupt router ports.
 Assumes a master that keeps the setup/access order.
*/
`timescale 1ns/1ns
`default_nettype none
module router_checker (
   input wire logic        CLOCK,
   input wire logic        RST_N,
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   input wire logic        SYS_RESET_PIN_N,
   input wire logic [8:0]  PROC_IRQ,
   input wire logic        APP_IRQ,
   input wire logic        PROC_WAKE,
   input wire logic        WDOG_RESET,
   input wire logic        SYS_RESET_OUT
);
   default clocking @(posedge CLOCK); endclocking
   default disable iff (!RST_N);
   wire logic unmap = (PADDR[1:0] != 2'b00) || (PADDR > 8'h34);
   wire logic setup = PSEL && !PENABLE;
   logic      pin_irq_r;
   // Mirror of the control bit that turns the reset pin into a source
   always_ff @(posedge CLOCK or negedge RST_N)
      if (!RST_N)
         pin_irq_r <= 1'b0;
      else if (PSEL && PENABLE && PWRITE && PADDR == 8'h20)
         pin_irq_r <= PWDATA[4];
   ready_high_a: assert property (PREADY) else $error("ready low");
   err_phase_a: assert property (PSLVERR |-> PSEL && PENABLE) else $error("stray error");
   err_map_a: assert property (PSEL && PENABLE |-> PSLVERR == unmap)
      else $error("error flag does not match address");
   bad_read_a: assert property (setup && !PWRITE && unmap |=> PRDATA == 32'h0)
      else $error("unmapped read not zero");
   sw_read_a: assert property (setup && !PWRITE && PADDR == 8'h24 |=> PRDATA == 32'h0)
      else $error("software set register reads nonzero");
   rdata_hold_a: assert property (!setup |=> $stable(PRDATA)) else $error("read data moved");
   wdog_pulse_a: assert property (WDOG_RESET |=> !WDOG_RESET) else $error("reset pulse long");
   reset_out_a: assert property (!pin_irq_r && !$past(pin_irq_r)
      |-> SYS_RESET_OUT == !$past(SYS_RESET_PIN_N)) else $error("reset output wrong");
   reset_quiet_a: assert property ($rose(RST_N) |-> PROC_IRQ == 9'h0 && !APP_IRQ && !PROC_WAKE)
      else $error("outputs busy after reset");
   cover property (PROC_WAKE);
   cover property (APP_IRQ);
   cover property (WDOG_RESET);
endmodule
bind system_interrupt_router router_checker i_chk (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(PSEL),
   .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .SYS_RESET_PIN_N(SYS_RESET_PIN_N), .PROC_IRQ(PROC_IRQ),
   .APP_IRQ(APP_IRQ), .PROC_WAKE(PROC_WAKE), .WDOG_RESET(WDOG_RESET),
   .SYS_RESET_OUT(SYS_RESET_OUT));
`default_nettype wire

//--- test/irq_sink.sv
/*
 Model of both processors taking interrupt lines.
 Assumes lines are levels in the CLOCK domain.
*/
`timescale 1ns/1ns
`default_nettype none
module irq_sink (
   input wire logic       CLOCK,
   input wire logic       RST_N,
   input wire logic [8:0] proc_irq,
   input wire logic       app_irq,
   output logic [8:0]     taken
);
   // Records every subsystem line served; the single app line lands in bit 0
   always_ff @(posedge CLOCK or negedge RST_N)
      if (!RST_N)
         taken <= 9'h0;
      else
         taken <= taken | proc_irq | {8'h0, app_irq};
endmodule
`default_nettype wire

//--- test/test_system_interrupt_router.sv
/*
 Bench for the interrupt router: APB tasks and source stimulus.
 Assumes the design and the checker are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_system_interrupt_router;
   logic CLOCK = 1'b0, RST_N = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0, pin = 8'hff, msg = 8'h0;
   logic [31:0] pwdata = 32'h0, rdata;
   logic [3:0] fab = 4'hf;
   logic acc = 1'b0, sysn = 1'b1, tick = 1'b0, derr = 1'b0, cfg = 1'b0, boot = 1'b1;
   logic adc = 1'b0, rtc = 1'b0;
   logic [15:0] sacc = 16'h0, sub = 16'h0;
   logic [4:0] ser = 5'h0;
   logic [11:0] dma = 12'h0;
   logic [19:0] fifo = 20'h0;
   logic [9:0] voice = 10'h0;
   wire [31:0] prdata;
   wire [8:0] pirq, taken;
   wire pready, airq, wake, wdog, rout;
   int err_total = 0, num_checks = 0, i;
   system_interrupt_router i_dut (.CLOCK(CLOCK), .RST_N(RST_N), .PSEL(psel), .PENABLE(penable),
      .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(), .PIN_IRQ(pin), .FABRIC_IRQ(fab), .BUS_ACC(acc), .BUS_RESP(1'b0),
      .SRAM_ACC(sacc), .SRAM_LOWPWR(16'h0001), .FUSION_MSG(msg), .FUSION_SUB(sub),
      .SERIAL_IRQ(ser), .SYS_RESET_PIN_N(sysn), .PM_TICK(tick), .DMA_DONE(dma), .DMA_ERR(derr),
      .FIFO_EVT(fifo), .VOICE_IRQ(voice), .CFG_DMA_DONE(cfg), .BOOT_FLASH(boot), .ADC_DONE(adc),
      .RTC_ALARM(rtc), .PROC_IRQ(pirq), .APP_IRQ(airq), .PROC_WAKE(wake), .WDOG_RESET(wdog),
      .SYS_RESET_OUT(rout));
   irq_sink i_sink (.CLOCK(CLOCK), .RST_N(RST_N), .proc_irq(pirq), .app_irq(airq), .taken(taken));
   always #4 CLOCK = ~CLOCK;
   ////////////////////////////////////////////////////////////////////////
   task chk(input [31:0] got, input [31:0] exp);
      num_checks++;
      if (got !== exp)
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp)
         err_total++;
   endtask
   task xfer(input w, input [7:0] a, input [31:0] d);
      @(posedge CLOCK);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge CLOCK);
      penable <= 1'b1;
      do @(posedge CLOCK); while (pready !== 1'b1);
      rdata = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rd(input [7:0] a, input [31:0] m, input [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rdata & m, e);
   endtask
   task settle(input int n);
      repeat (n) @(posedge CLOCK);
      #1;
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge CLOCK);
      err_total++;
      end_sim;
   end
   initial begin
      repeat (16) @(posedge CLOCK);
      RST_N <= 1'b1;
      for (i = 0; i <= 'h38; i += 4)
         rd(i[7:0], 32'hffffffff, 32'h0);
      $display("test 1 done");
      xfer(1, 8'h08, 32'hffffffff);
      xfer(1, 8'h0c, 32'hffffffff);
      xfer(1, 8'h10, 32'h1ff);
      @(posedge CLOCK);
      {sacc, msg, sub, ser, derr, fifo, dma, voice, cfg, adc, rtc} <= '1;
      @(posedge CLOCK);
      {sacc, msg, sub, ser, derr, fifo, dma, voice, cfg, adc, rtc} <= '0;
      settle(5);
      chk({23'h0, pirq}, 32'h1fc);
      rd(8'h00, 32'hffffffff, 32'hc3ff8000);
      rd(8'h04, 32'hffffffff, 32'h01ffffff);
      xfer(1, 8'h00, 32'hffffffff);
      xfer(1, 8'h04, 32'hffffffff);
      xfer(1, 8'h18, 32'h1ff);
      settle(5);
      chk({21'h0, pirq, wake, airq}, 32'h0);
      $display("test 2 done");
      xfer(1, 8'h1c, 32'h01010001);
      xfer(1, 8'h14, 32'h2);
      pin[0] <= 1'b0;
      settle(2);
      pin[0] <= 1'b1;
      settle(5);
      chk({23'h0, pirq}, 32'h3);
      chk({31'h0, airq}, 32'h1);
      rd(8'h00, 32'hffffffff, 32'h101);
      fab[0] <= 1'b0;
      xfer(1, 8'h00, 32'hffffffff);
      rd(8'h00, 32'hffffffff, 32'h0);
      $display("test 3 done");
      xfer(1, 8'h18, 32'h1ff);
      xfer(1, 8'h08, 32'h0);
      xfer(1, 8'h0c, 32'h1);
      dma[0] <= 1'b1;
      settle(1);
      dma[0] <= 1'b0;
      settle(5);
      chk({31'h0, wake}, 32'h0);
      xfer(1, 8'h0c, 32'h3);
      dma[1] <= 1'b1;
      settle(1);
      dma[1] <= 1'b0;
      settle(5);
      chk({31'h0, wake}, 32'h1);
      xfer(1, 8'h24, 32'h3);
      rd(8'h00, 32'hffffffff, 32'h0c000000);
      $display("test 4 done");
      xfer(1, 8'h28, 32'h5);
      xfer(1, 8'h2c, 32'h3);
      xfer(1, 8'h20, 32'h7);
      acc <= 1'b1;
      for (i = 0; i < 60 && wdog !== 1'b1; i++)
         settle(1);
      chk({31'h0, wdog}, 32'h1);
      settle(930);
      rd(8'h00, 32'h3000, 32'h2000);
      settle(90);
      rd(8'h00, 32'h3000, 32'h3000);
      acc <= 1'b0;
      xfer(1, 8'h20, 32'h0);
      $display("test 5 done");
      sysn <= 1'b0;
      settle(3);
      chk({31'h0, rout}, 32'h1);
      sysn <= 1'b1;
      xfer(1, 8'h30, 32'h2);
      xfer(1, 8'h20, 32'h18);
      sysn <= 1'b0;
      repeat (4) begin
         settle(2);
         tick <= 1'b1;
         settle(1);
         tick <= 1'b0;
      end
      chk({31'h0, rout}, 32'h0);
      rd(8'h00, 32'h30000000, 32'h30000000);
      sysn <= 1'b1;
      chk({23'h0, taken}, 32'h1ff);
      $display("test 6 done");
      end_sim;
   end
endmodule
`default_nettype wire
